/* cbeps_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cbeps_params.svh"
module cbeps_top
  import cbeps_pkg::*;
#(
  parameter int NUM_PROFILES = 3,
  parameter int ACC_W = `CBEPS_ACC_W,
  parameter int SQUELCH_CYC = `CBEPS_SQUELCH_CYC,
  parameter logic [2:0] PIN_FN_ONE = 3'h1,
  parameter logic [2:0] PIN_FN_TWO = 3'h6,
  parameter logic [2:0] PIN_FN_THREE = 3'h6,
  parameter logic [2:0] PIN_FN_FOUR = 3'h7,
  parameter logic [2:0] PIN_FN_FIVE = 3'h2,
  // per-profile, per-bank frequency words: out = fvco * word / 2^ACC_W
  parameter logic [ACC_W-1:0] FREQ_WORD [3][4] = '{default: 24'h200000}
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // power-on reset pulse
  input wire logic por_i,
  // multi-function control pins
  input wire logic multi_pin_one_i,
  input wire logic multi_pin_two_i,
  input wire logic multi_pin_three_i,
  input wire logic multi_pin_four_i,
  input wire logic multi_pin_five_i,
  // clock outputs, two per bank
  output logic [1:0] bank_a_outputs_o,
  output logic [1:0] bank_b_outputs_o,
  output logic [1:0] bank_c_outputs_o,
  output logic [1:0] bank_d_outputs_o,
  // status
  output logic [1:0] active_profile_o,
  output logic squelch_o,
  output logic reserved_select_o
);
  localparam int NP = `CBEPS_NUM_PINS;
  localparam int NB = `CBEPS_NUM_BANKS;

  // elaboration-time refusal of settings the logic cannot serve
  if (NUM_PROFILES < 1 || NUM_PROFILES > 3) begin : g_bad_profiles
    $error("cbeps_top: NUM_PROFILES must be 1..3");
  end
  if (ACC_W < 4) begin : g_bad_acc
    $error("cbeps_top: ACC_W too small");
  end
  if (SQUELCH_CYC < 1 || SQUELCH_CYC > 65535) begin : g_bad_squelch
    $error("cbeps_top: SQUELCH_CYC must fit the 16-bit counter");
  end
  if (PIN_FN_ONE == 3'h6 || PIN_FN_FOUR == 3'h6 || PIN_FN_FIVE == 3'h6) begin : g_bad_sel
    $error("cbeps_top: select only on pins two and three");
  end
  if (PIN_FN_TWO == 3'h7) begin : g_bad_rst
    $error("cbeps_top: reset not allowed on pin two");
  end

  // five pins, one fixed function each
  wire [NP-1:0] pin_lvl = {multi_pin_five_i, multi_pin_four_i, multi_pin_three_i,
                           multi_pin_two_i, multi_pin_one_i};
  wire [2:0] pin_fn [NP];
  assign pin_fn[0] = PIN_FN_ONE;
  assign pin_fn[1] = PIN_FN_TWO;
  assign pin_fn[2] = PIN_FN_THREE;
  assign pin_fn[3] = PIN_FN_FOUR;
  assign pin_fn[4] = PIN_FN_FIVE;

  // function decode: unassigned disables read low, i.e. enabled
  wire [NP-1:0] hit_master, hit_a, hit_b, hit_c, hit_d, hit_rst;
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_pin
      assign hit_master[gp] = pin_lvl[gp] && pin_fn[gp] == CBEPS_FN_MASTER;
      assign hit_a[gp] = pin_lvl[gp] && pin_fn[gp] == CBEPS_FN_BANK_A;
      assign hit_b[gp] = pin_lvl[gp] && pin_fn[gp] == CBEPS_FN_BANK_B;
      assign hit_c[gp] = pin_lvl[gp] && pin_fn[gp] == CBEPS_FN_BANK_C;
      assign hit_d[gp] = pin_lvl[gp] && pin_fn[gp] == CBEPS_FN_BANK_D;
      assign hit_rst[gp] = pin_lvl[gp] && pin_fn[gp] == CBEPS_FN_RESET;
    end
  endgenerate

  wire has_reset_pin = (PIN_FN_ONE == CBEPS_FN_RESET) || (PIN_FN_THREE == CBEPS_FN_RESET) ||
                       (PIN_FN_FOUR == CBEPS_FN_RESET) || (PIN_FN_FIVE == CBEPS_FN_RESET);
  wire master_output_disable_n = |hit_master;
  wire [NB-1:0] bank_disable_n = {|hit_d, |hit_c, |hit_b, |hit_a};
  wire [NB-1:0] bank_want_on = ~bank_disable_n & {NB{~master_output_disable_n}};

  wire profile_select_lo = (PIN_FN_TWO == CBEPS_FN_SEL) ? multi_pin_two_i : 1'b0;
  wire profile_select_hi = (PIN_FN_THREE == CBEPS_FN_SEL) ? multi_pin_three_i : 1'b0;
  wire [1:0] profile_select = {profile_select_hi, profile_select_lo};
  wire dev_reset = |hit_rst;

  // profile decode; reserved 00 keeps the current profile
  logic [1:0] decoded_prof;
  wire sel_reserved = NUM_PROFILES == 3 && profile_select == 2'h0;
  always_comb begin
    decoded_prof = 2'h0;
    if (NUM_PROFILES == 2) begin
      decoded_prof = {1'b0, profile_select_hi};
    end else if (NUM_PROFILES == 3) begin
      decoded_prof = profile_select - 2'h1;
    end
  end

  // adoption: reset pin if assigned, else only power-on
  cbeps_state_t st_q, st_d;
  logic [1:0] prof_q, prof_d;
  logic [15:0] sq_cnt_q, sq_cnt_d;
  wire adopt_req = has_reset_pin ? dev_reset : por_i;
  always_comb begin
    st_d = st_q;
    prof_d = prof_q;
    sq_cnt_d = sq_cnt_q;
    unique case (st_q)
      CBEPS_ST_RUN: begin
        if (adopt_req) begin
          st_d = CBEPS_ST_HOLD;
        end
      end
      CBEPS_ST_HOLD: begin
        // sample on leaving reset only
        if (!adopt_req) begin
          if (!sel_reserved) begin
            prof_d = decoded_prof;
          end
          sq_cnt_d = 16'(SQUELCH_CYC);
          st_d = CBEPS_ST_SQUELCH;
        end
      end
      CBEPS_ST_SQUELCH: begin
        if (adopt_req) begin
          st_d = CBEPS_ST_HOLD;
        end else if (sq_cnt_q <= 16'h1) begin
          st_d = CBEPS_ST_RUN;
        end else begin
          sq_cnt_d = sq_cnt_q - 16'h1;
        end
      end
      default: begin
        // code 3 is unused; fall back to a safe squelched state
        st_d = CBEPS_ST_HOLD;
      end
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q <= CBEPS_ST_HOLD;
      prof_q <= 2'h0;
      sq_cnt_q <= 16'h0;
    end else begin
      st_q <= st_d;
      prof_q <= prof_d;
      sq_cnt_q <= sq_cnt_d;
    end
  end
  wire squelch = st_q != CBEPS_ST_RUN;

  // fractional dividers: accumulator msb toggles at f*word/2^ACC_W,
  // each period spanning the two nearest integer cycle counts
  wire [NB-1:0] div_clk;
  wire [NB-1:0] out_bit;
  genvar gb;
  generate
    for (gb = 0; gb < NB; gb++) begin : g_bank
      logic [ACC_W-1:0] acc_q;
      logic gate_q;
      logic out_q;
      wire [ACC_W-1:0] word = FREQ_WORD[prof_q][gb];
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || squelch) begin
          acc_q <= '0;
        end else begin
          acc_q <= acc_q + word;
        end
      end
      assign div_clk[gb] = acc_q[ACC_W-1];
      // gate changes only while the divided clock is low: no runts
      wire gate_d = div_clk[gb] ? gate_q : (bank_want_on[gb] && !squelch);
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          gate_q <= 1'b0;
          out_q <= 1'b0;
        end else begin
          gate_q <= gate_d;
          out_q <= div_clk[gb] && gate_d && !squelch;
        end
      end
      assign out_bit[gb] = out_q;
    end
  endgenerate

  // reference mode and crystal mode both feed sys_clk_i here
  assign bank_a_outputs_o = {2{out_bit[0]}};
  assign bank_b_outputs_o = {2{out_bit[1]}};
  assign bank_c_outputs_o = {2{out_bit[2]}};
  assign bank_d_outputs_o = {2{out_bit[3]}};
  assign active_profile_o = prof_q;
  assign squelch_o = squelch;
  assign reserved_select_o = sel_reserved;
endmodule : cbeps_top
`default_nettype wire

/* cbeps_params.svh */
// Contract
// - master disable low enables all, high disables all
// - four active-low bank enables, two outputs each
// - disabled bank outputs held static low
// - bank start and stop without runt pulses
// - two profiles: upper select bit picks profile
// - three profiles: 01,10,11 map; 00 reserved
// - outputs squelched during profile change
// - no reset pin: profile changes only at power-on
// - enables assignable to any multi-function pin
// - select lo on pin two, hi on three
// - exactly five configurable control inputs
// - at most three stored frequency profiles
// - crystal mode free-runs at 25 or 27 MHz; here there is no crystal mode, sys_clk_i is used as is
// - reference mode locks to 5 to 200 MHz; here nothing locks, sys_clk_i is used as is
// - each path 1 to 200 MHz independently; here one word per bank, and both outputs of a bank are identical
// - divider alternates two nearest integer ratios
`ifndef CBEPS_PARAMS_SVH
`define CBEPS_PARAMS_SVH
`define CBEPS_CLK_MHZ 100
`define CBEPS_RESET_MIN_NS 200
`define CBEPS_RESET_MIN_CYC ((`CBEPS_RESET_MIN_NS * `CBEPS_CLK_MHZ + 999) / 1000)
`define CBEPS_SQUELCH_CYC 16
`define CBEPS_NUM_PINS 5
`define CBEPS_NUM_BANKS 4
`define CBEPS_ACC_W 24
`endif

/* cbeps_pkg.sv */
package cbeps_pkg;
  // function assigned to each multi-function pin at configuration time
  typedef enum logic [2:0] {
    CBEPS_FN_NONE,
    CBEPS_FN_MASTER,
    CBEPS_FN_BANK_A,
    CBEPS_FN_BANK_B,
    CBEPS_FN_BANK_C,
    CBEPS_FN_BANK_D,
    CBEPS_FN_SEL,
    CBEPS_FN_RESET
  } cbeps_fn_t;
  typedef enum logic [1:0] {
    CBEPS_PROF_1,
    CBEPS_PROF_2,
    CBEPS_PROF_3
  } cbeps_prof_t;
  typedef enum logic [1:0] {
    CBEPS_ST_RUN,
    CBEPS_ST_HOLD,
    CBEPS_ST_SQUELCH
  } cbeps_state_t;
endpackage : cbeps_pkg

/* cbeps_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module cbeps_top_asserts #(
  parameter int SQUELCH_CYC = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // pins
  input wire logic multi_pin_one_i,
  input wire logic multi_pin_two_i,
  input wire logic multi_pin_three_i,
  input wire logic multi_pin_four_i,
  input wire logic multi_pin_five_i,
  // outputs
  input wire logic [1:0] bank_a_outputs_o,
  input wire logic [1:0] bank_b_outputs_o,
  input wire logic [1:0] bank_c_outputs_o,
  input wire logic [1:0] bank_d_outputs_o,
  input wire logic [1:0] active_profile_o,
  input wire logic squelch_o,
  input wire logic reserved_select_o
);
  // assumes the default pin map: master, select lo, select hi, reset, bank A
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire [7:0] outs = {bank_d_outputs_o, bank_c_outputs_o, bank_b_outputs_o, bank_a_outputs_o};
  wire [1:0] sel = {multi_pin_three_i, multi_pin_two_i};
  localparam int SQ_END = SQUELCH_CYC + 1;
  a_master_off: assert property (multi_pin_one_i [*8] |-> outs == 8'h00)
    else $error("outputs run while master off");
  a_bank_a_off: assert property (multi_pin_five_i [*8] |-> bank_a_outputs_o == 2'h0)
    else $error("bank A runs while off");
  a_pair_equal: assert property ((outs & 8'h55) == ((outs >> 1) & 8'h55))
    else $error("bank pair differs");
  a_squelch_low: assert property (squelch_o && $past(squelch_o) |-> outs == 8'h00)
    else $error("outputs run while squelched");
  a_no_runt: assert property ($rose(bank_a_outputs_o[0]) |=> (bank_a_outputs_o[0] || squelch_o) [*3])
    else $error("short high pulse");
  a_profile_hold: assert property ((!multi_pin_four_i) [*4] |=> $stable(active_profile_o))
    else $error("profile moved without reset");
  a_reset_squelch: assert property ($rose(multi_pin_four_i) |=> squelch_o)
    else $error("no squelch on reset");
  a_squelch_ends: assert property ($fell(multi_pin_four_i) |-> ##[1:SQ_END] !squelch_o)
    else $error("squelch too long");
  a_profile_map: assert property ($fell(multi_pin_four_i) && sel != 2'h0 |-> ##[1:2] active_profile_o == sel - 2'h1)
    else $error("wrong profile");
  a_reserved_flag: assert property (reserved_select_o == (sel == 2'h0))
    else $error("reserved flag wrong");
endmodule : cbeps_top_asserts
bind cbeps_top cbeps_top_asserts #(.SQUELCH_CYC(SQUELCH_CYC)) u_chk (.sys_clk_i, .sys_rst_i,
  .multi_pin_one_i, .multi_pin_two_i,
  .multi_pin_three_i, .multi_pin_four_i, .multi_pin_five_i, .bank_a_outputs_o, .bank_b_outputs_o,
  .bank_c_outputs_o, .bank_d_outputs_o, .active_profile_o, .squelch_o, .reserved_select_o);
`default_nettype wire

/* cbeps_board.sv */
`timescale 1ns/1ps
`default_nettype none
module cbeps_board (
  // clock
  input wire logic sys_clk_i,
  // requests
  input wire logic mst_i,
  input wire logic bnk_i,
  input wire logic go_i,
  input wire logic [1:0] sel_i,
  // pins, pin one in bit 0
  output logic [4:0] pin_o
);
  logic [4:0] cnt_q = 5'h00;
  // reset held 20 cycles so a select change is adopted
  always_ff @(posedge sys_clk_i) begin
    if (go_i) begin
      cnt_q <= 5'h14;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
  assign pin_o = {bnk_i, cnt_q != 5'h00, sel_i, mst_i};
endmodule : cbeps_board
`default_nettype wire

/* cbeps_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cbeps_top_test;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic mst = 1'b0, bnk = 1'b0, go = 1'b0, por = 1'b0, sq, rsv;
  logic [1:0] sel = 2'h1;
  logic [1:0] prof;
  wire [4:0] pin;
  wire [7:0] outs;
  int err_total = 0, check_count = 0, cyc = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  cbeps_board u_board (.sys_clk_i, .mst_i(mst), .bnk_i(bnk), .go_i(go), .sel_i(sel), .pin_o(pin));
  cbeps_top #(.SQUELCH_CYC(4)) u_dut (.sys_clk_i, .sys_rst_i, .por_i(por),
    .multi_pin_one_i(pin[0]), .multi_pin_two_i(pin[1]), .multi_pin_three_i(pin[2]),
    .multi_pin_four_i(pin[3]), .multi_pin_five_i(pin[4]), .bank_a_outputs_o(outs[1:0]),
    .bank_b_outputs_o(outs[3:2]), .bank_c_outputs_o(outs[5:4]), .bank_d_outputs_o(outs[7:6]),
    .active_profile_o(prof), .squelch_o(sq), .reserved_select_o(rsv));
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic test_done;
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // settle past the gate lag, then collect every output bit that went high
  task automatic watch(output logic [7:0] s);
    step(10);
    s = 8'h00;
    repeat (16) begin
      s |= outs;
      step(1);
    end
  endtask : watch
  task automatic t_gate;
    logic [7:0] seen;
    mst = 1'b1;
    watch(seen);
    chk("master_off", seen, 8'h00);
    mst = 1'b0;
    bnk = 1'b1;
    watch(seen);
    chk("bank_a_off", seen, 8'hFC);
    bnk = 1'b0;
    watch(seen);
    chk("all_on", seen, 8'hFF);
  endtask : t_gate
  task automatic t_prof(input logic [1:0] s);
    sel = s;
    step(1);
    go = 1'b1;
    step(1);
    go = 1'b0;
    step(2);
    chk("squelch", {7'h0, sq}, 8'h01);
    step(30);
    chk("profile", {6'h0, prof}, {6'h0, s - 2'h1});
    chk("unsquelch", {7'h0, sq}, 8'h00);
    sel = s - 2'h1;
    step(10);
    chk("held", {6'h0, prof}, {6'h0, s - 2'h1});
    chk("reserved", {7'h0, rsv}, {7'h0, s == 2'h1});
  endtask : t_prof
  // reserved select is refused; power-on pulse is ignored while a reset pin exists
  task automatic t_rsv;
    sel = 2'h0;
    step(1);
    go = 1'b1;
    step(1);
    go = 1'b0;
    step(32);
    chk("rsv_keep", {6'h0, prof}, 8'h02);
    chk("rsv_flag", {7'h0, rsv}, 8'h01);
    chk("rsv_unsquelch", {7'h0, sq}, 8'h00);
    sel = 2'h1;
    por = 1'b1;
    step(20);
    por = 1'b0;
    step(10);
    chk("por_ignored", {6'h0, prof}, 8'h02);
    chk("por_no_squelch", {7'h0, sq}, 8'h00);
  endtask : t_rsv
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    step(20);
    sys_rst_i = 1'b0;
    step(10);
    chk("boot_profile", {6'h0, prof}, 8'h00);
    t_gate();
    t_prof(2'h2);
    t_prof(2'h3);
    t_rsv();
    t_prof(2'h1);
    test_done();
  end
endmodule : cbeps_top_test
`default_nettype wire
